/* File: src/pmcs_top.sv */
// conversion sequencer and background arithmetic of a power monitor
// assumes one shared converter whose result sits on adc_sample when
// sample_take pulses, and a classic wishbone master on the bus side
// What this block does
// [R1] power is latest current times newest bus
// [R2] zero shunt calibration gives zero power
// [R3] averaging accumulates current and power, loads at end
// [R4] arithmetic runs beside conversions, adds no time
// [R5] only inputs enabled by mode are converted
// [R6] no averaging: each input result updates at its conversion end, current and power two cycles after the bus one
// [R7] each input has its own conversion time
// [R8] enabled inputs convert one after another
// [R9] averaging repeats whole sequence before results load
// [R10] results hold until next complete result; reads harmless
// [R11] continuous mode loops without host action
// [R12] triggered mode runs one sequence then shuts down
// [R13] mode write aborts and restarts conversions
// [R14] ready flag sets after conversions and averaging
// [R15] setup write clears ready unless selecting shutdown
// [R16] diagnostic register read clears ready flag
// [R17] start delay up to 510 ms in 2 ms
// [R18] start delay resets to zero
// [R19] averaging one to 1024, same for all inputs
// [R20] shutdown: registers usable, idle until mode write
// [R21] delay counted once before first conversion
`timescale 1ns/100ps
`include "pmcs_consts.svh"

module pmcs_top #(
  parameter int unsigned DLY_STEP_US = `PMCS_DLY_STEP_US
) (
  input  wire  logic        clk_sys,
  input  wire  logic        reset_n,
  input  wire  logic        wb_cyc,
  input  wire  logic        wb_stb,
  input  wire  logic        wb_we,
  input  wire  logic [7:0]  wb_adr,
  input  wire  logic [3:0]  wb_sel,
  input  wire  logic [31:0] wb_dat_w,
  output logic       [31:0] wb_dat_r,
  output logic              wb_ack,
  input  wire  logic [15:0] adc_sample,
  output logic       [1:0]  adc_chan,
  output logic              adc_busy,
  output logic              sample_take,
  output logic              conversion_ready
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [12:0] ct_us(input logic [2:0] c);
    logic [12:0] t;
    t = `PMCS_CT0_US;
    unique case (c)
      3'h0: t = `PMCS_CT0_US;
      3'h1: t = `PMCS_CT1_US;
      3'h2: t = `PMCS_CT2_US;
      3'h3: t = `PMCS_CT3_US;
      3'h4: t = `PMCS_CT4_US;
      3'h5: t = `PMCS_CT5_US;
      3'h6: t = `PMCS_CT6_US;
      3'h7: t = `PMCS_CT7_US;
    endcase
    return t;
  endfunction : ct_us

  // tick count to load for a channel, one less than its time
  function automatic logic [12:0] ct_load(input pmcs_pkg::pmcs_adc_cfg_s c,
                                          input logic [1:0] ch);
    logic [12:0] t;
    t = ct_us(c.ct_tmp);
    if (ch == 2'(pmcs_pkg::ch_shunt)) t = ct_us(c.ct_sh);
    else if (ch == 2'(pmcs_pkg::ch_bus)) t = ct_us(c.ct_bus);
    return 13'(t - 13'h1);
  endfunction : ct_load

  // averages 1,4,16,64,128,256,512,1024 as a shift
  function automatic logic [3:0] avg_shift(input logic [2:0] a);
    logic [3:0] s;
    s = 4'h0;
    unique case (a)
      3'h0: s = 4'h0;
      3'h1: s = 4'h2;
      3'h2: s = 4'h4;
      3'h3: s = 4'h6;
      3'h4: s = 4'h7;
      3'h5: s = 4'h8;
      3'h6: s = 4'h9;
      3'h7: s = 4'ha;
    endcase
    return s;
  endfunction : avg_shift

  function automatic logic [1:0] first_ch(input logic [2:0] en);
    logic [1:0] c;
    c = 2'(pmcs_pkg::ch_temp);
    if (en[0]) c = 2'(pmcs_pkg::ch_shunt);
    else if (en[1]) c = 2'(pmcs_pkg::ch_bus);
    return c;
  endfunction : first_ch

  // {found, channel} of the next enabled input after cur
  function automatic logic [2:0] next_ch(input logic [2:0] en,
                                         input logic [1:0] cur);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (i > int'(cur) && en[i]) r = {1'b1, 2'(i)};
    end
    return r;
  endfunction : next_ch

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [1:0]  sel);
    return {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_q1_r;
  logic rst_n_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n_r  <= rst_q1_r;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n_r);

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave and registers

  pmcs_pkg::pmcs_adc_cfg_s cfg_r;
  pmcs_pkg::pmcs_adc_cfg_s cfg_nxt;
  pmcs_pkg::pmcs_state_e   state_r;
  logic [7:0]              dly_r;
  logic [14:0]             cal_r;
  logic                    ack_r;
  logic                    hit;
  logic                    wr_setup;
  logic                    rd_diag;
  logic                    rdy_r;
  logic [15:0]             res_sh_r;
  logic [15:0]             res_bus_r;
  logic [15:0]             res_tmp_r;
  logic [15:0]             res_cur_r;
  logic [23:0]             res_pwr_r;
  logic [10:0]             pass_r;
  logic [31:0]             rd_mux;
  logic [15:0]             cal_nxt;

  assign hit      = wb_cyc & wb_stb & ~ack_r;
  assign wr_setup = hit & wb_we & (wb_adr == `PMCS_ADR_SETUP);
  assign rd_diag  = hit & ~wb_we & (wb_adr == `PMCS_ADR_DIAG);
  assign cfg_nxt  = merge16(cfg_r, wb_dat_w[15:0], wb_sel[1:0]);
  assign cal_nxt  = merge16({1'b0, cal_r}, wb_dat_w[15:0], wb_sel[1:0]);
  assign wb_ack   = ack_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= hit;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r <= `PMCS_SETUP_RST;
      dly_r <= `PMCS_DLY_RST; // R18
      cal_r <= `PMCS_CAL_RST;
    end else if (hit && wb_we) begin
      if (wb_adr == `PMCS_ADR_SETUP) cfg_r <= cfg_nxt;
      if (wb_adr == `PMCS_ADR_CONFIG && wb_sel[0])
        dly_r[1:0] <= wb_dat_w[`PMCS_DLY_LSB+1:`PMCS_DLY_LSB];
      if (wb_adr == `PMCS_ADR_CONFIG && wb_sel[1])
        dly_r[7:2] <= wb_dat_w[`PMCS_DLY_MSB:`PMCS_DLY_LSB+2];
      if (wb_adr == `PMCS_ADR_CAL)
        cal_r <= cal_nxt[14:0];
    end
  end

  // result reads only sample flops, so conversions never notice them
  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_adr)
      `PMCS_ADR_CONFIG:  rd_mux[`PMCS_DLY_MSB:`PMCS_DLY_LSB] = dly_r;
      `PMCS_ADR_SETUP:   rd_mux[15:0] = cfg_r;
      `PMCS_ADR_CAL:     rd_mux[14:0] = cal_r;
      `PMCS_ADR_DIAG:    rd_mux[`PMCS_RDY_BIT] = rdy_r;
      `PMCS_ADR_RES_SH:  rd_mux[15:0] = res_sh_r; // R10
      `PMCS_ADR_RES_BUS: rd_mux[15:0] = res_bus_r;
      `PMCS_ADR_RES_TMP: rd_mux[15:0] = res_tmp_r;
      `PMCS_ADR_RES_CUR: rd_mux[15:0] = res_cur_r;
      `PMCS_ADR_RES_PWR: rd_mux[23:0] = res_pwr_r;
      `PMCS_ADR_STATUS:  rd_mux = {5'h0, pass_r, 14'h0, 2'(state_r)};
      default:           rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wb_dat_r <= 32'h0;
    end else if (hit && !wb_we) begin
      wb_dat_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // microsecond tick

  logic [3:0] tick_cnt_r;
  logic       tick;

  assign tick = (tick_cnt_r == 4'(`PMCS_TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) tick_cnt_r <= 4'h0;
    else tick_cnt_r <= tick ? 4'h0 : 4'(tick_cnt_r + 4'h1);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  logic [1:0]  ch_r;
  logic [12:0] ct_cnt_r;
  logic [18:0] dly_cnt_r;
  logic [2:0]  nx;
  logic [1:0]  fc;
  logic [10:0] navg;
  logic        last_pass;
  logic        seq_end;

  assign nx          = next_ch(cfg_r.en, ch_r);
  assign fc          = first_ch(cfg_r.en);
  assign navg        = 11'(11'h1 << avg_shift(cfg_r.avg)); // R19
  assign last_pass   = (pass_r == 11'(navg - 11'h1));
  assign sample_take = (state_r == pmcs_pkg::st_conv) && tick
                       && (ct_cnt_r == 13'h0);
  assign seq_end     = sample_take & ~nx[2] & last_pass;
  assign adc_chan    = ch_r;
  assign adc_busy    = (state_r == pmcs_pkg::st_conv);

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r   <= pmcs_pkg::st_delay;
      ch_r      <= 2'(pmcs_pkg::ch_shunt);
      ct_cnt_r  <= 13'h0;
      dly_cnt_r <= 19'h0;
      pass_r    <= 11'h0;
    end else if (wr_setup) begin
      pass_r <= 11'h0; // R13
      if (cfg_nxt.en == 3'h0) begin
        state_r <= pmcs_pkg::st_idle; // R20
      end else begin
        state_r   <= pmcs_pkg::st_delay; // R13
        ch_r      <= first_ch(cfg_nxt.en); // R5
        dly_cnt_r <= 19'(dly_r * DLY_STEP_US); // R17 R21
      end
    end else begin
      unique case (state_r)
        pmcs_pkg::st_idle: begin
        end
        pmcs_pkg::st_delay: begin
          if (dly_cnt_r == 19'h0) begin
            state_r  <= pmcs_pkg::st_conv;
            ct_cnt_r <= ct_load(cfg_r, ch_r); // R7
          end else if (tick) begin
            dly_cnt_r <= 19'(dly_cnt_r - 19'h1); // R21
          end
        end
        pmcs_pkg::st_conv: begin
          if (tick && ct_cnt_r != 13'h0) begin
            ct_cnt_r <= 13'(ct_cnt_r - 13'h1);
          end else if (sample_take && nx[2]) begin
            ch_r     <= nx[1:0]; // R8
            ct_cnt_r <= ct_load(cfg_r, nx[1:0]); // R7
          end else if (sample_take) begin
            ch_r     <= fc;
            ct_cnt_r <= ct_load(cfg_r, fc);
            if (!last_pass) pass_r <= 11'(pass_r + 11'h1); // R9
            else begin
              pass_r <= 11'h0;
              if (!cfg_r.cont) state_r <= pmcs_pkg::st_idle; // R12 R11
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // background arithmetic and results

  logic               calc1_r;
  logic               calc2_r;
  logic               seq_done_r;
  logic               final_go;
  logic [15:0]        sh_last_r;
  logic [15:0]        bus_last_r;
  logic signed [15:0] cur_r;
  logic signed [31:0] cur_prod;
  logic signed [32:0] pwr_prod;
  logic [23:0]        pwr_now;
  logic signed [26:0] acc_sh_r;
  logic signed [26:0] acc_bus_r;
  logic signed [26:0] acc_tmp_r;
  logic signed [26:0] acc_cur_r;
  logic signed [33:0] acc_pwr_r;
  logic [3:0]         shf;

  // own pipeline, so conversions never wait on it
  assign cur_prod = $signed(sh_last_r) * $signed({1'b0, cal_r}); // R4
  assign pwr_prod = cur_r * $signed({1'b0, bus_last_r}); // R1
  assign pwr_now  = (cal_r == 15'h0) ? 24'h0 : pwr_prod[31:8]; // R2
  assign final_go = seq_done_r & ~calc1_r & ~calc2_r; // R14
  assign shf      = avg_shift(cfg_r.avg);

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      calc1_r    <= 1'b0;
      calc2_r    <= 1'b0;
      cur_r      <= 16'sh0;
      seq_done_r <= 1'b0;
    end else begin
      calc1_r <= sample_take && ch_r == 2'(pmcs_pkg::ch_bus)
                 && cfg_r.en[0]; // R1
      calc2_r <= calc1_r;
      if (calc1_r) cur_r <= cur_prod[27:12];
      if (seq_end) seq_done_r <= 1'b1;
      else if (final_go || wr_setup) seq_done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sh_last_r <= 16'h0;
      bus_last_r <= 16'h0;
      res_sh_r  <= 16'h0;
      res_bus_r <= 16'h0;
      res_tmp_r <= 16'h0;
      res_cur_r <= 16'h0;
      res_pwr_r <= 24'h0;
      acc_sh_r  <= 27'sh0;
      acc_bus_r <= 27'sh0;
      acc_tmp_r <= 27'sh0;
      acc_cur_r <= 27'sh0;
      acc_pwr_r <= 34'sh0;
    end else if (wr_setup) begin
      acc_sh_r  <= 27'sh0;
      acc_bus_r <= 27'sh0;
      acc_tmp_r <= 27'sh0;
      acc_cur_r <= 27'sh0;
      acc_pwr_r <= 34'sh0;
    end else begin
      if (sample_take) begin
        unique case (ch_r)
          2'(pmcs_pkg::ch_shunt): begin
            sh_last_r <= adc_sample;
            if (navg == 11'h1) res_sh_r <= adc_sample; // R6
            else acc_sh_r <= acc_sh_r + {{11{adc_sample[15]}}, adc_sample};
          end
          2'(pmcs_pkg::ch_bus): begin
            bus_last_r <= adc_sample;
            if (navg == 11'h1) res_bus_r <= adc_sample; // R6
            else acc_bus_r <= acc_bus_r + {11'h0, adc_sample};
          end
          default: begin
            if (navg == 11'h1) res_tmp_r <= adc_sample; // R6
            else acc_tmp_r <= acc_tmp_r + {{11{adc_sample[15]}}, adc_sample};
          end
        endcase
      end
      if (calc2_r && navg == 11'h1) begin
        res_cur_r <= cur_r;
        res_pwr_r <= pwr_now;
      end else if (calc2_r) begin
        acc_cur_r <= acc_cur_r + {{11{cur_r[15]}}, cur_r}; // R3
        acc_pwr_r <= acc_pwr_r + {{10{pwr_now[23]}}, pwr_now}; // R3
      end
      if (final_go && navg != 11'h1) begin
        res_sh_r  <= 16'(acc_sh_r >>> shf); // R9
        res_bus_r <= 16'(acc_bus_r >>> shf);
        res_tmp_r <= 16'(acc_tmp_r >>> shf);
        res_cur_r <= 16'(acc_cur_r >>> shf); // R3
        res_pwr_r <= 24'(acc_pwr_r >>> shf);
        acc_sh_r  <= 27'sh0;
        acc_bus_r <= 27'sh0;
        acc_tmp_r <= 27'sh0;
        acc_cur_r <= 27'sh0;
        acc_pwr_r <= 34'sh0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion-ready flag: a completion in the clearing cycle wins

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) rdy_r <= 1'b0;
    else if (final_go) rdy_r <= 1'b1; // R14
    else if (rd_diag || (wr_setup && cfg_nxt.en != 3'h0))
      rdy_r <= 1'b0; // R15 R16
  end

  assign conversion_ready = rdy_r;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  property p_rdy_set;
    $rose(rdy_r) |-> $past(final_go);
  endproperty
  a_rdy_set: assert property (p_rdy_set) // R14
    else $error("ready flag rose without sequence end");

  property p_rd_clear;
    rd_diag && !final_go |=> !rdy_r;
  endproperty
  a_rd_clear: assert property (p_rd_clear) // R16
    else $error("diagnostic read left ready set");

  property p_wr_clear;
    wr_setup && !final_go |=> (rdy_r == (cfg_r.en == 3'h0 && $past(rdy_r)));
  endproperty
  a_wr_clear: assert property (p_wr_clear) // R15
    else $error("setup write gave wrong ready flag");

  property p_restart;
    wr_setup |=> (cfg_r.en == 3'h0) ? state_r == pmcs_pkg::st_idle
                 : (state_r == pmcs_pkg::st_delay && pass_r == 11'h0);
  endproperty
  a_restart: assert property (p_restart) // R13
    else $error("mode write did not restart");

  property p_delay_end;
    state_r == pmcs_pkg::st_delay && dly_cnt_r == 19'h0 && !wr_setup
      |=> state_r == pmcs_pkg::st_conv;
  endproperty
  a_delay_end: assert property (p_delay_end) // R17
    else $error("conversion did not start after delay");

  property p_cal_zero;
    calc2_r && cal_r == 15'h0 && navg == 11'h1 && !wr_setup
      |=> res_pwr_r == 24'h0;
  endproperty
  a_cal_zero: assert property (p_cal_zero) // R2
    else $error("power not zero with zero calibration");

  property p_direct;
    sample_take && navg == 11'h1 && ch_r == 2'(pmcs_pkg::ch_shunt)
      && !wr_setup |=> res_sh_r == $past(adc_sample);
  endproperty
  a_direct: assert property (p_direct) // R6
    else $error("shunt result not updated at conversion end");

  property p_enabled;
    sample_take |-> cfg_r.en[ch_r];
  endproperty
  a_enabled: assert property (p_enabled) // R5
    else $error("disabled input converted");

  property p_trig_stop;
    seq_end && !cfg_r.cont && !wr_setup |=> state_r == pmcs_pkg::st_idle;
  endproperty
  a_trig_stop: assert property (p_trig_stop) // R12
    else $error("triggered mode did not shut down");

  property p_hold;
    navg != 11'h1 && !final_go |=> $stable(res_sh_r) && $stable(res_cur_r);
  endproperty
  a_hold: assert property (p_hold) // R10
    else $error("averaged result changed early");

  c_avg_done: cover property (final_go && navg != 11'h1);
  c_cont_loop: cover property (seq_end && cfg_r.cont);
  c_trig_done: cover property (seq_end && !cfg_r.cont);
  c_set_clear: cover property (final_go && rd_diag);

endmodule : pmcs_top

/* File: src/pmcs_consts.svh */
// constants of the power monitor conversion sequencer
// assumes a 10 MHz system clock and a 32-bit classic wishbone bus
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH
// register byte offsets
`define PMCS_ADR_CONFIG  8'h00
`define PMCS_ADR_SETUP   8'h04
`define PMCS_ADR_CAL     8'h08
`define PMCS_ADR_DIAG    8'h0c
`define PMCS_ADR_RES_SH  8'h10
`define PMCS_ADR_RES_BUS 8'h14
`define PMCS_ADR_RES_TMP 8'h18
`define PMCS_ADR_RES_CUR 8'h1c
`define PMCS_ADR_RES_PWR 8'h20
`define PMCS_ADR_STATUS  8'h24
// field positions
`define PMCS_DLY_LSB     6
`define PMCS_DLY_MSB     13
`define PMCS_RDY_BIT     1
// reset values
`define PMCS_SETUP_RST   16'hfb68
`define PMCS_DLY_RST     8'h00
`define PMCS_CAL_RST     15'h0000
// timing
`define PMCS_CLK_NS      100
`define PMCS_TICK_NS     1000
`define PMCS_TICK_CYCLES (`PMCS_TICK_NS / `PMCS_CLK_NS)
`define PMCS_DLY_STEP_MS 2
`define PMCS_DLY_STEP_US (`PMCS_DLY_STEP_MS * 1000)
`define PMCS_CT0_US      13'd50
`define PMCS_CT1_US      13'd84
`define PMCS_CT2_US      13'd150
`define PMCS_CT3_US      13'd280
`define PMCS_CT4_US      13'd540
`define PMCS_CT5_US      13'd1052
`define PMCS_CT6_US      13'd2074
`define PMCS_CT7_US      13'd4120
`endif

/* File: src/pmcs_pkg.sv */
// types of the power monitor conversion sequencer
// assumes nothing beyond the constants header
package pmcs_pkg;
  typedef enum logic [1:0] {st_idle, st_delay, st_conv} pmcs_state_e;
  typedef enum logic [1:0] {ch_shunt, ch_bus, ch_temp} pmcs_chan_e;
  // converter setup: cont=1 continuous, en[0] shunt, en[1] bus, en[2] temp
  typedef struct packed {
    logic       cont;
    logic [2:0] en;
    logic [2:0] ct_bus;
    logic [2:0] ct_sh;
    logic [2:0] ct_tmp;
    logic [2:0] avg;
  } pmcs_adc_cfg_s;
endpackage : pmcs_pkg

/* File: dv/pmcs_adc_model.sv */
// converter stand-in: per-channel value stepping on every take
// assumes adc_chan stands through a conversion and sample_take ends it
`timescale 1ns/100ps
module pmcs_adc_model (
  input  wire logic             clk_sys,
  input  wire logic [1:0]       adc_chan,
  input  wire logic             adc_busy,
  input  wire logic             sample_take,
  input  wire logic             clr,
  input  wire logic [2:0][15:0] base,
  input  wire logic [15:0]      step,
  output logic      [15:0]      adc_sample
);
  logic [2:0][15:0] n_r;
  always @(posedge clk_sys) begin
    if (clr) n_r <= '0;
    else if (sample_take && adc_chan != 2'h3) n_r[adc_chan] <= n_r[adc_chan] + 16'h0001;
    // idle output wanders so a stale sample never passes
    if (adc_busy && adc_chan != 2'h3) adc_sample <= base[adc_chan] + n_r[adc_chan] * step;
    else adc_sample <= (adc_sample === 16'h5a5a) ? 16'ha5a5 : 16'h5a5a;
  end
endmodule : pmcs_adc_model

/* File: dv/tb_power_monitor_conversion_sequencer.sv */
// random bench of the conversion sequencer and its arithmetic
// assumes the hand-over register map and a 2 us delay step
`timescale 1ns/100ps
`include "pmcs_consts.svh"
module tb_power_monitor_conversion_sequencer;
  localparam int unsigned STEP = 2;
  localparam int TK = `PMCS_TICK_CYCLES;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r, rd;
  logic wb_ack, adc_busy, sample_take, conversion_ready, clr = 1'b0;
  logic [1:0] adc_chan, last_chan;
  logic [15:0] adc_sample, sv, bv, cv, step = 16'h0000;
  logic [2:0][15:0] base = '0;
  logic [14:0] cal;
  logic [31:0] ss, sb, si, sp;
  pmcs_pkg::pmcs_adc_cfg_s cfg;
  int bad_count = 0;
  int n_tests = 0;
  int ntake [3];
  int ivl [3];
  int cyc_n = 0;
  int k;

  always #50 clk_sys = ~clk_sys;

  pmcs_top #(.DLY_STEP_US(STEP)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .adc_sample(adc_sample), .adc_chan(adc_chan),
    .adc_busy(adc_busy), .sample_take(sample_take),
    .conversion_ready(conversion_ready));
  pmcs_adc_model u_adc (.clk_sys(clk_sys), .adc_chan(adc_chan),
    .adc_busy(adc_busy), .sample_take(sample_take), .clr(clr),
    .base(base), .step(step), .adc_sample(adc_sample));

  ////////////////////////////////////////////////////////////////////////////
  // converter-side monitor: takes per channel and cycles per conversion
  always @(posedge clk_sys) begin
    cyc_n = cyc_n + 1;
    if (sample_take === 1'b1 && adc_chan != 2'h3) begin
      ntake[adc_chan] = ntake[adc_chan] + 1;
      ivl[adc_chan] = cyc_n;
      last_chan = adc_chan;
      cyc_n = 0;
    end
    if (adc_busy !== 1'b1) cyc_n = 0;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic fail_out;
    bad_count++;
    report_and_stop();
  endtask : fail_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // cycle counts, not design values: a window check
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("unexpected at %0t: got %h window %h %h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat_w <= d;
    i = 0;
    // ack and read data are taken at the rising edge that shows ack
    do begin
      @(posedge clk_sys);
      i++;
    end while (wb_ack !== 1'b1 && i < 50);
    if (wb_ack !== 1'b1) fail_out();
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb
  task automatic wait_ready;
    int i;
    for (i = 0; i < 30000 && conversion_ready !== 1'b1; i++) @(posedge clk_sys);
    if (conversion_ready !== 1'b1) fail_out();
  endtask : wait_ready
  // writes setup, then times the start delay
  task automatic run(input pmcs_pkg::pmcs_adc_cfg_s c, input int dly);
    int n;
    clr <= 1'b1;
    ntake = '{0, 0, 0};
    wb(1'b1, `PMCS_ADR_SETUP, {16'h0000, c});
    clr <= 1'b0;
    chk(conversion_ready, 1'b0);
    for (n = 0; n < 2000 && adc_busy !== 1'b1; n++) @(posedge clk_sys);
    // first tick is partial: up to one tick early, two cycles late
    chk_rng(n, dly - 10, dly + 2);
    if (adc_busy !== 1'b1) fail_out();
  endtask : run
  function automatic int ct(logic [2:0] c);
    return (c == 3'd0 ? `PMCS_CT0_US : `PMCS_CT1_US) * TK;
  endfunction : ct
  function automatic logic [15:0] f_cur(logic [15:0] s, logic [14:0] c);
    logic [31:0] p;
    p = s * c;
    return p[27:12];
  endfunction : f_cur
  function automatic logic [23:0] f_pwr(logic [15:0] i, logic [15:0] b);
    logic [31:0] p;
    p = i * b;
    return p[31:8];
  endfunction : f_pwr

  initial begin
    void'($urandom(32'h2a26c7ab));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wb(1'b0, `PMCS_ADR_CONFIG, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, `PMCS_ADR_CONFIG, 32'h0000_3fc0);
    wb(1'b0, `PMCS_ADR_CONFIG, 32'h0);
    chk(rd, 32'h0000_3fc0);
    // triggered shunt and bus, delay 3 steps, distinct times
    wb(1'b1, `PMCS_ADR_CONFIG, 32'h0000_00c0);
    cal = 15'($urandom_range(32'h7fff, 1));
    // shunt kept low so current never overflows into its sign bit
    base[0] <= 16'($urandom_range(32'h0fcf, 0));
    base[1] <= 16'($urandom);
    base[2] <= 16'($urandom);
    wb(1'b1, `PMCS_ADR_CAL, {17'h0, cal});
    cfg = '{1'b0, 3'b011, 3'd1, 3'd0, 3'd0, 3'd0};
    run(cfg, 3 * STEP * TK);
    wait_ready();
    wb(1'b0, `PMCS_ADR_RES_SH, 32'h0);
    chk(rd, {16'h0, base[0]});
    wb(1'b0, `PMCS_ADR_RES_BUS, 32'h0);
    chk(rd, {16'h0, base[1]});
    wb(1'b0, `PMCS_ADR_RES_CUR, 32'h0);
    chk(rd, {16'h0, f_cur(base[0], cal)});
    wb(1'b0, `PMCS_ADR_RES_PWR, 32'h0);
    chk(rd, {8'h0, f_pwr(f_cur(base[0], cal), base[1])});
    chk_rng(ivl[0], ct(3'd0) - 12, ct(3'd0) + 3);
    chk_rng(ivl[1], ct(3'd1) - 12, ct(3'd1) + 3);
    chk(ntake[2], 0);
    chk(ntake[0] + ntake[1], 2);
    wb(1'b0, `PMCS_ADR_STATUS, 32'h0);
    chk(rd[1:0], 2'h0);
    wb(1'b0, `PMCS_ADR_DIAG, 32'h0);
    chk(rd[`PMCS_RDY_BIT], 1'b1);
    wb(1'b0, `PMCS_ADR_DIAG, 32'h0);
    chk(rd[`PMCS_RDY_BIT], 1'b0);
    // zero calibration, all three inputs
    wb(1'b1, `PMCS_ADR_CONFIG, 32'h0);
    wb(1'b1, `PMCS_ADR_CAL, 32'h0);
    cfg = '{1'b0, 3'b111, 3'd0, 3'd0, 3'd0, 3'd0};
    run(cfg, 0);
    wait_ready();
    wb(1'b0, `PMCS_ADR_RES_PWR, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, `PMCS_ADR_RES_TMP, 32'h0);
    chk(rd, {16'h0, base[2]});
    // four passes with stepping samples; reads mid-run
    cal = 15'($urandom_range(32'h7fff, 1));
    wb(1'b1, `PMCS_ADR_CAL, {17'h0, cal});
    step <= 16'h0010;
    cfg.avg = 3'd1;
    run(cfg, 0);
    for (k = 0; k < 5000 && ntake[1] < 2; k++) @(posedge clk_sys);
    if (ntake[1] < 2) fail_out();
    wb(1'b0, `PMCS_ADR_RES_SH, 32'h0);
    chk(rd, {16'h0, base[0]});
    wait_ready();
    ss = 0;
    sb = 0;
    si = 0;
    sp = 0;
    for (k = 0; k < 4; k++) begin
      sv = base[0] + 16'(k) * step;
      bv = base[1] + 16'(k) * step;
      cv = f_cur(sv, cal);
      ss += sv;
      sb += bv;
      si += cv;
      sp += f_pwr(cv, bv);
    end
    chk(ntake[0] + ntake[1] + ntake[2], 12);
    wb(1'b0, `PMCS_ADR_RES_SH, 32'h0);
    chk(rd, {16'h0, ss[17:2]});
    wb(1'b0, `PMCS_ADR_RES_BUS, 32'h0);
    chk(rd, {16'h0, sb[17:2]});
    wb(1'b0, `PMCS_ADR_RES_CUR, 32'h0);
    chk(rd, {16'h0, si[17:2]});
    wb(1'b0, `PMCS_ADR_RES_PWR, 32'h0);
    chk(rd, {8'h0, sp[25:2]});
    // shutdown keeps the flag and the registers
    wb(1'b1, `PMCS_ADR_SETUP, 32'h0000_0000);
    chk(conversion_ready, 1'b1);
    wb(1'b1, `PMCS_ADR_CAL, 32'h0000_1234);
    wb(1'b0, `PMCS_ADR_CAL, 32'h0);
    chk(rd, 32'h0000_1234);
    repeat (300) @(posedge clk_sys);
    chk(adc_busy, 1'b0);
    // continuous loops, then a rewrite mid bus conversion restarts
    step <= 16'h0000;
    cfg = '{1'b1, 3'b011, 3'd1, 3'd0, 3'd0, 3'd0};
    run(cfg, 0);
    wait_ready();
    wb(1'b0, `PMCS_ADR_DIAG, 32'h0);
    chk(conversion_ready, 1'b0);
    wait_ready();
    for (k = 0; k < 3000 && !(adc_busy && adc_chan == 2'h1); k++) @(posedge clk_sys);
    if (!(adc_busy === 1'b1 && adc_chan === 2'h1)) fail_out();
    repeat (200) @(posedge clk_sys);
    run(cfg, 0);
    for (k = 0; k < 3000 && ntake[0] + ntake[1] == 0; k++) @(posedge clk_sys);
    if (ntake[0] + ntake[1] == 0) fail_out();
    chk(last_chan, 2'h0);
    chk_rng(ivl[0], ct(3'd0) - 12, ct(3'd0) + 3);
    wb(1'b1, `PMCS_ADR_SETUP, 32'h0);
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    fail_out();
  end
endmodule : tb_power_monitor_conversion_sequencer
